//--- dac_ctrl_pkg.sv
// Shared constants for the octal converter serial control block
package dac_ctrl_pkg;

	// Channel and code geometry
	localparam int CHANNELS = 8;
	localparam int CODE_W   = 16;
	localparam int WORD_W   = 24;

	// Frame bit counting on the serial clock
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam logic [4:0] FRAME_LAST = 5'h17;

	// Field positions inside the 24-bit serial word
	localparam int CMD_LSB  = 20;
	localparam int CMD_W    = 4;
	localparam int ADDR_LSB = 16;
	localparam int ADDR_W   = 4;
	localparam int DATA_LSB = 0;

	// Command codes and the channel address limit
	localparam logic [3:0] CMD_WRITE_INPUT   = 4'h1;
	localparam logic [3:0] CMD_WRITE_THROUGH = 4'h3;
	localparam logic [3:0] ADDR_LIMIT        = 4'h8;

	// Preset codes for power-up and pin reset
	localparam logic [15:0] ZERO_CODE = 16'h0000;
	localparam logic [15:0] MID_CODE  = 16'h8000;

	// Cycles after reset release before the pins are trusted
	localparam logic [2:0] SETTLE_LAST = 3'h5;
	localparam logic [2:0] SETTLE_DONE = 3'h6;

	// Synchroniser lanes and their reset values
	localparam int SYNC_COUNT  = 5;
	localparam int SYNC_STROBE = 0;
	localparam int SYNC_RESET  = 1;
	localparam int SYNC_SPAN   = 2;
	localparam int SYNC_LEVEL  = 3;
	localparam int SYNC_TOGGLE = 4;
	localparam logic [4:0] SYNC_INIT = 5'h03;

endpackage

//--- pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns

module pin_sync
#(
	parameter logic RESET_VALUE = 1'b0
)
(
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic async_i,
	output logic      stable_o
);

	logic stage1;
	logic stage2;
	logic stage3;

	////////////////////////////////////////////////////////////////
	// Shift chain; only stage2 reads stage1
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			stage1 <= RESET_VALUE;
			stage2 <= RESET_VALUE;
			stage3 <= RESET_VALUE;
		end
		else
		begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Output moves only when the last two stages agree
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			stable_o <= RESET_VALUE;
		else if (stage2 == stage3)
			stable_o <= stage3;
	end

endmodule

//--- octal_dac_serial_control_pins.sv
// Serial write port and channel register control for the octal converter
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Frame sync low opens a frame; the next 24 falling edges carry bits.
// - Bits shift in on falling serial clock edges at up to 50 MHz.
// - A 24-bit shift register collects the word of each write frame.
// - Span select low gives zero to reference, high zero to twice it.
// - At power-up all channels start at zero or midscale per level select.
// - A low load strobe copies pending inputs to their outputs together.
// - The strobe may be pulsed or held low so that writes update outputs.
// - Serial out changes on rising edges and is valid at falling edges.
// - The reset pin acts on its falling edge, apart from the serial clock.
// - While the reset pin is low every load strobe is ignored.
// - Reset loads input and output registers with the selected preset.
// - The zero-scale code is all zeros in the 16-bit data word.
module octal_dac_serial_control_pins
(
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic        sclk_i,
	input  wire logic        frame_sync_n_i,
	input  wire logic        serial_in_i,
	input  wire logic        load_strobe_n_i,
	input  wire logic        reset_n_i,
	input  wire logic        span_select_i,
	input  wire logic        reset_level_select_i,
	output logic             serial_out_o,
	output logic             span_double_o,
	output logic [7:0][15:0] channel_code_o
);

	// Link domain state
	logic [4:0]  bit_count;
	logic [23:0] shift_reg;
	logic [23:0] frame_word;
	logic        word_toggle;

	// Reference domain state
	logic [4:0]  sync_stable;
	logic        strobe_prev;
	logic        rst_prev;
	logic        toggle_prev;
	logic [2:0]  settle_count;
	logic        word_valid;
	logic [23:0] word_reg;
	logic [7:0]  pending;
	logic [7:0][15:0] input_code;
	logic [7:0][15:0] next_input;
	logic [7:0][15:0] next_output;

	////////////////////////////////////////////////////////////////
	// Link domain decode
	wire logic        shift_en   = !frame_sync_n_i &&
		(bit_count < dac_ctrl_pkg::FRAME_BITS);
	wire logic        frame_done = !frame_sync_n_i &&
		(bit_count == dac_ctrl_pkg::FRAME_LAST);
	wire logic [23:0] next_shift = {shift_reg[22:0], serial_in_i};

	// Bit counter, cleared while the frame is idle
	always_ff @(negedge sclk_i or posedge frame_sync_n_i)
	begin
		if (frame_sync_n_i)
			bit_count <= 5'h00;
		else if (bit_count < dac_ctrl_pkg::FRAME_BITS)
			bit_count <= bit_count + 5'h01;
	end

	// Shift on falling edges, hand over the word at the last bit
	always_ff @(negedge sclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			shift_reg   <= 24'h000000;
			frame_word  <= 24'h000000;
			word_toggle <= 1'b0;
		end
		else
		begin
			if (shift_en)
				shift_reg <= next_shift;
			if (frame_done)
				frame_word <= next_shift;
			if (frame_done)
				word_toggle <= ~word_toggle;
		end
	end

	// Serial out launched on rising edges
	always_ff @(posedge sclk_i or posedge reset_i)
	begin
		if (reset_i)
			serial_out_o <= 1'b0;
		else
			serial_out_o <= shift_reg[23];
	end

	////////////////////////////////////////////////////////////////
	// Pin and toggle synchronisers
	wire logic [4:0] sync_raw = {word_toggle, reset_level_select_i,
		span_select_i, reset_n_i, load_strobe_n_i};

	genvar g;
	generate
		for (g = 0; g < dac_ctrl_pkg::SYNC_COUNT; g++)
		begin : g_sync
			pin_sync
			#(
				.RESET_VALUE (dac_ctrl_pkg::SYNC_INIT[g])
			)
			u_sync
			(
				.ref_clk_i (ref_clk_i),
				.reset_i   (reset_i),
				.async_i   (sync_raw[g]),
				.stable_o  (sync_stable[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Channel address to one-hot mask, out of range gives none
	function automatic logic [7:0] channel_mask
	(
		input logic [3:0] addr
	);
		logic [7:0] mask;
		mask = 8'h00;
		if (addr < dac_ctrl_pkg::ADDR_LIMIT)
			mask[addr[2:0]] = 1'b1;
		return mask;
	endfunction

	// Synchronised pin views and event detection
	wire logic strobe_s   = sync_stable[dac_ctrl_pkg::SYNC_STROBE];
	wire logic rst_s      = sync_stable[dac_ctrl_pkg::SYNC_RESET];
	wire logic span_s     = sync_stable[dac_ctrl_pkg::SYNC_SPAN];
	wire logic level_s    = sync_stable[dac_ctrl_pkg::SYNC_LEVEL];
	wire logic toggle_s   = sync_stable[dac_ctrl_pkg::SYNC_TOGGLE];
	wire logic word_event = toggle_s != toggle_prev;
	wire logic rst_low    = !rst_s;
	wire logic rst_fall   = rst_prev && !rst_s;
	wire logic init_fire  = settle_count == dac_ctrl_pkg::SETTLE_LAST;
	wire logic load_all   = init_fire || rst_fall;

	// Preset code chosen by the reset level pin
	wire logic [15:0] preset_code = level_s ? dac_ctrl_pkg::MID_CODE :
		dac_ctrl_pkg::ZERO_CODE;

	// Word field decode
	wire logic [3:0]  cmd  = word_reg[dac_ctrl_pkg::CMD_LSB +:
		dac_ctrl_pkg::CMD_W];
	wire logic [3:0]  addr = word_reg[dac_ctrl_pkg::ADDR_LSB +:
		dac_ctrl_pkg::ADDR_W];
	wire logic [15:0] data = word_reg[dac_ctrl_pkg::DATA_LSB +:
		dac_ctrl_pkg::CODE_W];
	wire logic [7:0]  write_hit = (word_valid &&
		cmd == dac_ctrl_pkg::CMD_WRITE_INPUT) ? channel_mask(addr) : 8'h00;
	wire logic [7:0]  through_hit = (word_valid &&
		cmd == dac_ctrl_pkg::CMD_WRITE_THROUGH) ? channel_mask(addr) : 8'h00;

	// Strobe low copies pending channels unless reset pin is low
	wire logic       update_now   = !rst_low && !strobe_s;
	wire logic [7:0] upd_mask     = update_now ? pending : 8'h00;
	wire logic [7:0] next_pending = load_all ? 8'h00 :
		((pending & ~upd_mask) | write_hit);

	// Per-channel next values for input and output registers
	genvar c;
	generate
		for (c = 0; c < dac_ctrl_pkg::CHANNELS; c++)
		begin : g_chan
			assign next_input[c] = load_all ? preset_code :
				(write_hit[c] || through_hit[c]) ? data :
				input_code[c];
			assign next_output[c] = load_all ? preset_code :
				through_hit[c] ? data :
				upd_mask[c] ? input_code[c] :
				channel_code_o[c];
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Edge history and power-up settle counter
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			strobe_prev  <= 1'b1;
			rst_prev     <= 1'b1;
			toggle_prev  <= 1'b0;
			settle_count <= 3'h0;
		end
		else
		begin
			strobe_prev <= strobe_s;
			rst_prev    <= rst_s;
			toggle_prev <= toggle_s;
			if (settle_count != dac_ctrl_pkg::SETTLE_DONE)
				settle_count <= settle_count + 3'h1;
		end
	end

	// Capture a complete word from the link domain
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			word_valid <= 1'b0;
			word_reg   <= 24'h000000;
		end
		else
		begin
			word_valid <= word_event;
			if (word_event)
				word_reg <= frame_word;
		end
	end

	// Channel registers and span output
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			pending        <= 8'h00;
			input_code     <= '0;
			channel_code_o <= '0;
			span_double_o  <= 1'b0;
		end
		else
		begin
			pending        <= next_pending;
			input_code     <= next_input;
			channel_code_o <= next_output;
			span_double_o  <= span_s;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks on the link domain
	a_count_bound: assert property (
		@(negedge sclk_i) disable iff (frame_sync_n_i)
		bit_count <= dac_ctrl_pkg::FRAME_BITS)
		else $error("bit counter ran past frame length");

	a_shift_capture: assert property (
		@(negedge sclk_i) disable iff (reset_i)
		(!frame_sync_n_i && bit_count < dac_ctrl_pkg::FRAME_BITS)
		|=> shift_reg[0] == $past(serial_in_i))
		else $error("serial bit not shifted in on falling edge");

	a_word_handover: assert property (
		@(negedge sclk_i) disable iff (reset_i)
		frame_done |=> frame_word == $past(next_shift) &&
		word_toggle != $past(word_toggle))
		else $error("complete word not handed over");

	a_serial_out: assert property (
		@(negedge sclk_i) disable iff (frame_sync_n_i || reset_i)
		(bit_count != 5'h00) |-> serial_out_o == shift_reg[23])
		else $error("serial out not valid at falling edge");

	// Checks on the reference domain
	a_partial_drop: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(!word_valid && !load_all) |=> $stable(input_code))
		else $error("input registers moved without a full frame");

	a_span_follow: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		span_s ##1 span_s |=> span_double_o)
		else $error("span output does not follow select");

	a_zero_preset: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(init_fire && !level_s) |=> channel_code_o == '0)
		else $error("zero scale preset not all zeros");

	a_mid_preset: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(init_fire && level_s) |=>
		channel_code_o == {dac_ctrl_pkg::CHANNELS{dac_ctrl_pkg::MID_CODE}})
		else $error("midscale preset not applied at power-up");

	a_pin_reset: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		rst_fall |=>
		input_code == {dac_ctrl_pkg::CHANNELS{$past(preset_code)}} &&
		channel_code_o == input_code)
		else $error("reset pin did not preset both registers");

	a_strobe_ignored: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(rst_low && !load_all && through_hit == 8'h00)
		|=> $stable(channel_code_o))
		else $error("output changed while reset pin low");

	a_strobe_copy: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(update_now && pending[0] && !load_all && !through_hit[0])
		|=> channel_code_o[0] == $past(input_code[0]) && !pending[0] ||
		$past(write_hit[0]))
		else $error("strobe did not copy pending channel");

	a_held_low: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(write_hit[0] && !load_all) ##1
		(update_now && !load_all && word_valid == 1'b0)
		|=> channel_code_o[0] == $past(input_code[0]))
		else $error("held low strobe did not update channel");

	a_output_only: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(!load_all && !update_now && through_hit == 8'h00)
		|=> $stable(channel_code_o))
		else $error("output register changed without cause");

	a_pending_clear: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		load_all |=> pending == 8'h00)
		else $error("preset left a pending channel");

	a_word_capture: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		word_event |=> word_valid && word_reg == $past(frame_word))
		else $error("word not captured from the link side");

	a_through_write: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		(through_hit[0] && !load_all) |=>
		channel_code_o[0] == $past(data) && input_code[0] == $past(data))
		else $error("write through did not reach channel");

	// Main scenarios
	c_full_frame: cover property (
		@(posedge ref_clk_i) disable iff (reset_i) word_valid);
	c_strobe_pulse: cover property (
		@(posedge ref_clk_i) disable iff (reset_i)
		strobe_prev && !strobe_s && pending != 8'h00 && !rst_low);
	c_pin_reset: cover property (
		@(posedge ref_clk_i) disable iff (reset_i) rst_fall);
	c_through: cover property (
		@(posedge ref_clk_i) disable iff (reset_i) through_hit != 8'h00);

endmodule

//--- host_model.sv
// Host model driving the serial write port
`timescale 1ns/1ns

module host_model
(
	input  wire logic serial_out_i,
	output logic      sclk_o,
	output logic      frame_sync_n_o,
	output logic      serial_data_o
);
	logic [23:0] seen;

	// Idle state: clock parked high, sync high
	initial
	begin
		sclk_o = 1'b1;
		frame_sync_n_o = 1'b1;
		serial_data_o = 1'b0;
		seen = 24'h000000;
	end

	////////////////////////////////////////////////////////////////
	// One frame of n bits, MSB first, 6 ns clock only inside it
	task automatic send(input logic [23:0] w, input int n);
		frame_sync_n_o = 1'b0;
		#9;
		for (int k = 0; k < n; k++)
		begin
			serial_data_o = w[23 - k];
			#3;
			seen[23 - k] = serial_out_i; // Older word shifting out
			sclk_o = 1'b0;
			#3;
			sclk_o = 1'b1;
		end
		#2;
		frame_sync_n_o = 1'b1; // Early rise cuts a short frame
		serial_data_o = ~serial_data_o; // Released line shows no stale bit
	endtask
endmodule

//--- tb_octal_dac_serial_control_pins.sv
// Self-checking bench for the serial control block
`timescale 1ns/1ns

module tb_octal_dac_serial_control_pins;
	logic             ref_clk_i;
	logic             reset_i;
	logic             load_strobe_n_i;
	logic             reset_n_i;
	logic             span_select_i;
	logic             reset_level_select_i;
	logic             sclk_i;
	logic             frame_sync_n_i;
	logic             serial_in_i;
	logic             serial_out_o;
	logic             span_double_o;
	logic [7:0][15:0] channel_code_o;
	logic [7:0][15:0] model;
	logic [7:0][15:0] pend;
	logic [7:0]       pmask;
	logic [23:0]      prev;
	logic [3:0]       cmds [3] = '{4'h1, 4'h3, 4'h7};
	int               fails;
	int               checks;
	int               seed;

	octal_dac_serial_control_pins DUT
	(
		.ref_clk_i            (ref_clk_i),
		.reset_i              (reset_i),
		.sclk_i               (sclk_i),
		.frame_sync_n_i       (frame_sync_n_i),
		.serial_in_i          (serial_in_i),
		.load_strobe_n_i      (load_strobe_n_i),
		.reset_n_i            (reset_n_i),
		.span_select_i        (span_select_i),
		.reset_level_select_i (reset_level_select_i),
		.serial_out_o         (serial_out_o),
		.span_double_o        (span_double_o),
		.channel_code_o       (channel_code_o)
	);

	host_model HOST
	(
		.serial_out_i   (serial_out_o),
		.sclk_o         (sclk_i),
		.frame_sync_n_o (frame_sync_n_i),
		.serial_data_o  (serial_in_i)
	);

	// 50 ns reference clock
	initial
	begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	////////////////////////////////////////////////////////////////
	// Expected preset code for a level
	function automatic logic [15:0] preset(input logic lvl);
		return lvl ? dac_ctrl_pkg::MID_CODE : 16'h0000;
	endfunction

	// Compare and count
	task automatic check(input string name, input logic [127:0] seen,
		input logic [127:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic close_out();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Reset held 3 cycles, then preset checked
	task automatic do_reset(input logic lvl);
		@(posedge ref_clk_i);
		reset_i <= 1'b1;
		reset_level_select_i <= lvl;
		repeat (3) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		repeat (10) @(posedge ref_clk_i);
		model = {8{preset(lvl)}};
		pmask = 8'h00;
		prev = 24'h000000;
		check("preset", channel_code_o, model);
	endtask

	// Pending inputs move to outputs
	task automatic copy_pending();
		for (int i = 0; i < 8; i++)
			if (pmask[i])
				model[i] = pend[i];
		pmask = 8'h00;
	endtask

	// One frame, then model update and compare
	task automatic wr(input logic [3:0] c, input logic [3:0] a,
		input logic [15:0] d, input int n);
		@(posedge ref_clk_i);
		#1;
		HOST.send({c, a, d}, n);
		repeat (20) @(posedge ref_clk_i);
		if (n == 24)
		begin
			check("serial_out", HOST.seen, prev);
			prev = {c, a, d};
			if (a < 4'h8 && c == 4'h3)
			begin
				model[a] = d;
				pend[a] = d; // Through write also fills the input
			end
			if (a < 4'h8 && c == 4'h1)
			begin
				pend[a] = d;
				pmask[a] = 1'b1;
			end
			if (!load_strobe_n_i && reset_n_i)
				copy_pending();
		end
		check("codes", channel_code_o, model);
	endtask

	// Low pulse of 4 cycles on the strobe
	task automatic pulse();
		@(posedge ref_clk_i);
		load_strobe_n_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		load_strobe_n_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		if (reset_n_i)
			copy_pending();
		check("strobe", channel_code_o, model);
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		seed = 32'hc20417bb;
		fails = 0;
		checks = 0;
		reset_i = 1'b1;
		load_strobe_n_i = 1'b1;
		reset_n_i = 1'b1;
		span_select_i = 1'b0;
		reset_level_select_i = 1'b1;
		pend = '0;
		do_reset(1'b1);
		do_reset(1'b0);
		for (int s = 1; s >= 0; s--)
		begin
			@(posedge ref_clk_i);
			span_select_i <= s[0];
			repeat (8) @(posedge ref_clk_i);
			check("span", span_double_o, s[0]);
		end
		// Random writes, bad addresses and commands among them
		for (int i = 0; i < 15; i++)
		begin
			wr(cmds[i % 3], 4'($unsigned($random(seed)) % 10),
				16'($random(seed)), 24);
			if (i % 4 == 3)
				pulse();
		end
		// Strobe held low updates without a pulse
		@(posedge ref_clk_i);
		load_strobe_n_i <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
		copy_pending();
		wr(4'h1, 4'h7, 16'hFFFF, 24);
		wr(4'h1, 4'h0, 16'h0001, 24);
		@(posedge ref_clk_i);
		load_strobe_n_i <= 1'b1;
		// Reset pin presets all, and blocks the strobe while low
		wr(4'h1, 4'h2, 16'h1234, 24);
		@(posedge ref_clk_i);
		reset_n_i <= 1'b0;
		repeat (10) @(posedge ref_clk_i);
		model = {8{preset(1'b0)}};
		pmask = 8'h00;
		check("pin_reset", channel_code_o, model);
		wr(4'h1, 4'h5, 16'hABCD, 24);
		pulse();
		@(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		pulse();
		// Short frames are dropped
		wr(4'h3, 4'h4, 16'h5A5A, 23);
		wr(4'h3, 4'h6, 16'hA5A5, 1);
		close_out();
	end

	// Hang guard
	initial
	begin
		#1000000;
		fails++;
		close_out();
	end
endmodule
